// ### inc/dstrb_pkg.sv
// drive status / trip holding-register bank: shared constants and types
// assumes one 20 MHz clock domain; request port fed by the link framing layer
`default_nettype none
package dstrb_pkg;
  // holding-register addresses
  localparam logic [15:0] ADDR_UNUSED = 16'h0000;
  localparam logic [15:0] ADDR_FREQ_HI = 16'h0001;
  localparam logic [15:0] ADDR_FREQ_LO = 16'h0002;
  localparam logic [15:0] ADDR_STATE_DETAIL = 16'h0003;
  localparam logic [15:0] ADDR_STATE_COARSE = 16'h0004;
  localparam logic [15:0] ADDR_MOTION = 16'h0005;
  localparam logic [15:0] ADDR_FEEDBACK = 16'h0006;
  localparam logic [15:0] ADDR_RSV_FIRST = 16'h0007;
  localparam logic [15:0] ADDR_RSV_LAST = 16'h0010;
  localparam logic [15:0] ADDR_FAULT_COUNT = 16'h0011;
  localparam logic [15:0] ADDR_F1_CAUSE = 16'h0012;
  localparam logic [15:0] ADDR_F1_STATE = 16'h0013;
  localparam logic [15:0] ADDR_F1_FREQ_HI = 16'h0014;
  localparam logic [15:0] ADDR_F1_FREQ_LO = 16'h0015;
  localparam logic [15:0] ADDR_F1_CURRENT = 16'h0016;
  localparam logic [15:0] ADDR_F1_VOLTAGE = 16'h0017;
  localparam logic [15:0] ADDR_F1_RUN_HI = 16'h0018;
  localparam logic [15:0] ADDR_F1_RUN_LO = 16'h0019;
  localparam logic [15:0] ADDR_F1_PWR_HI = 16'h001A;
  localparam logic [15:0] ADDR_F1_PWR_LO = 16'h001B;
  localparam logic [15:0] ADDR_F2_CAUSE = 16'h001C;
  // ranges, scale and selector values
  localparam logic [31:0] FREQ_MAX = 32'h0000_9C40;
  localparam logic [15:0] FEEDBACK_MAX = 16'h2710;
  localparam logic [15:0] FAULT_COUNT_MAX = 16'hFFFA;
  localparam logic [31:0] SCALE_HUNDRED = 32'h0000_0064;
  localparam logic [7:0] SRC_SEL_NETWORK = 8'h03;
  localparam logic [15:0] RESERVED_VALUE = 16'h0000;
  localparam int ERR_FLAGS = 5;
  // drive state detail codes
  typedef enum logic [3:0] {
    DS_INITIAL = 4'h0, DS_STOPPING = 4'h2, DS_RUNNING = 4'h3, DS_FREE_RUN = 4'h4,
    DS_JOGGING = 4'h5, DS_DC_BRAKE = 4'h6, DS_RETRYING = 4'h7, DS_TRIPPING = 4'h8,
    DS_UNDERVOLT = 4'h9
  } dstrb_detail_t;
  // coarse state codes
  typedef enum logic [1:0] {
    CS_STOPPING = 2'h0, CS_RUNNING = 2'h1, CS_TRIPPING = 2'h2
  } dstrb_coarse_t;
  // motion phase codes
  typedef enum logic [3:0] {
    MP_NONE = 4'h0, MP_STOPPING = 4'h1, MP_DECEL = 4'h2, MP_CONSTANT = 4'h3,
    MP_ACCEL = 4'h4, MP_FORWARD = 4'h5, MP_REVERSE = 4'h6, MP_FWD_TO_REV = 4'h7,
    MP_REV_TO_FWD = 4'h8, MP_START_FWD = 4'h9, MP_START_REV = 4'hA
  } dstrb_motion_t;
  // register request from the framing layer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dstrb_req_t;
  // register answer
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } dstrb_rsp_t;
  // snapshot of drive quantities taken at a trip
  typedef struct packed {
    logic [15:0] cause;
    logic [31:0] freq;
    logic [15:0] current;
    logic [15:0] voltage;
    logic [31:0] run_hours;
    logic [31:0] power_hours;
  } dstrb_trip_t;
endpackage
`default_nettype wire

// ### rtl/dstrb_bank.sv
// drive status / trip holding-register bank
// assumes requests come from same-clock framing logic, one at a time
//
// Functional notes
// - frequency setpoint 0..40000, used when source is 03
// - detail word reports the nine drive states
// - coarse word: stopping 0, running 1, tripping 2
// - motion phase word encodes codes 1 to 10
// - trip record holds cause then drive state
// - trip record keeps output current at trip
// - trip record keeps DC voltage at trip
// - trip record keeps run hours, high/low
// - trip record keeps power-on hours, high/low
// - wide values: high word at lower address
// - device divides received values by scale factor
// - LSB means listed resolution on both sides
// - comm errors sticky until reset, even running
`timescale 1ns/1ps
`default_nettype none
module dstrb_bank (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire dstrb_pkg::dstrb_req_t REQ_I,
  output dstrb_pkg::dstrb_rsp_t RSP_O,
  input wire logic [7:0] FREQ_SOURCE_SELECT_I,
  input wire dstrb_pkg::dstrb_detail_t DRIVE_STATE_I,
  input wire dstrb_pkg::dstrb_motion_t MOTION_PHASE_I,
  input wire logic TRIP_I,
  input wire dstrb_pkg::dstrb_trip_t TRIP_SNAP_I,
  input wire logic [dstrb_pkg::ERR_FLAGS-1:0] COMM_ERR_EVENT_I,
  input wire logic COMM_ERR_RESET_I,
  output logic [31:0] OUTPUT_FREQ_SETPOINT_O,
  output logic OUTPUT_FREQ_VALID_O,
  output logic [31:0] FREQ_WHOLE_HZ_O,
  output logic [15:0] FEEDBACK_O,
  output logic [15:0] FEEDBACK_WHOLE_PCT_O,
  output logic [dstrb_pkg::ERR_FLAGS-1:0] COMM_ERR_O
);
  import dstrb_pkg::*;

  logic [31:0] freq_r;
  logic [15:0] freq_hi_stage_r;
  logic [15:0] feedback_r;
  logic [15:0] fault_count_r;
  dstrb_trip_t fault1_r;
  dstrb_detail_t fault1_state_r;
  logic [15:0] fault2_cause_r;
  logic [ERR_FLAGS-1:0] comm_err_r;
  dstrb_rsp_t rsp_r;
  logic [31:0] freq_whole_r;
  logic [15:0] fb_whole_r;
  logic valid_r;
  dstrb_coarse_t coarse;
  logic [15:0] rd_val;
  logic rd_bad;
  logic wr_bad;
  logic [31:0] freq_cand;
  logic [31:0] fb_quot;

  // coarse state folded from the detail state
  always_comb begin
    unique case (DRIVE_STATE_I)
      DS_TRIPPING: coarse = CS_TRIPPING;
      DS_RUNNING, DS_JOGGING, DS_DC_BRAKE, DS_RETRYING: coarse = CS_RUNNING;
      default: coarse = CS_STOPPING;
    endcase
  end

  // read decode; high word sits at the lower address
  always_comb begin
    rd_val = RESERVED_VALUE;
    rd_bad = 1'b0;
    if (REQ_I.addr >= ADDR_RSV_FIRST && REQ_I.addr <= ADDR_RSV_LAST) begin
      rd_val = RESERVED_VALUE;
    end else begin
      unique case (REQ_I.addr)
        ADDR_FREQ_HI: rd_val = freq_r[31:16];
        ADDR_FREQ_LO: rd_val = freq_r[15:0];
        ADDR_STATE_DETAIL: rd_val = {12'h000, DRIVE_STATE_I};
        ADDR_STATE_COARSE: rd_val = {14'h0, coarse};
        ADDR_MOTION: rd_val = {12'h000, MOTION_PHASE_I};
        ADDR_FEEDBACK: rd_val = feedback_r;
        ADDR_FAULT_COUNT: rd_val = fault_count_r;
        ADDR_F1_CAUSE: rd_val = fault1_r.cause;
        ADDR_F1_STATE: rd_val = {12'h000, fault1_state_r};
        ADDR_F1_FREQ_HI: rd_val = fault1_r.freq[31:16];
        ADDR_F1_FREQ_LO: rd_val = fault1_r.freq[15:0];
        ADDR_F1_CURRENT: rd_val = fault1_r.current;
        ADDR_F1_VOLTAGE: rd_val = fault1_r.voltage;
        ADDR_F1_RUN_HI: rd_val = fault1_r.run_hours[31:16];
        ADDR_F1_RUN_LO: rd_val = fault1_r.run_hours[15:0];
        ADDR_F1_PWR_HI: rd_val = fault1_r.power_hours[31:16];
        ADDR_F1_PWR_LO: rd_val = fault1_r.power_hours[15:0];
        ADDR_F2_CAUSE: rd_val = fault2_cause_r;
        default: rd_bad = 1'b1; // address zero and beyond the map
      endcase
    end
  end

  // write check: only setpoint pair and feedback, each inside its range
  assign freq_cand = {freq_hi_stage_r, REQ_I.wdata};
  always_comb begin
    unique case (REQ_I.addr)
      ADDR_FREQ_HI: wr_bad = 1'b0;
      ADDR_FREQ_LO: wr_bad = (freq_cand > FREQ_MAX);
      ADDR_FEEDBACK: wr_bad = (REQ_I.wdata > FEEDBACK_MAX);
      default: wr_bad = 1'b1; // read-only, reserved or unmapped
    endcase
  end

  // answer, one cycle after the request
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      rsp_r <= '0;
    end else begin
      rsp_r.ack <= REQ_I.rd | REQ_I.wr;
      rsp_r.err <= (REQ_I.wr & wr_bad) | (REQ_I.rd & ~REQ_I.wr & rd_bad);
      rsp_r.rdata <= (REQ_I.rd & ~REQ_I.wr & ~rd_bad) ? rd_val : RESERVED_VALUE;
    end
  end

  // setpoint: high word staged, pair committed on the low-word write
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      freq_r <= '0;
      freq_hi_stage_r <= '0;
    end else if (REQ_I.wr && !wr_bad) begin
      if (REQ_I.addr == ADDR_FREQ_HI) begin
        freq_hi_stage_r <= REQ_I.wdata;
      end else if (REQ_I.addr == ADDR_FREQ_LO) begin
        freq_r <= freq_cand;
      end
    end
  end

  // feedback value
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      feedback_r <= '0;
    end else if (REQ_I.wr && !wr_bad && REQ_I.addr == ADDR_FEEDBACK) begin
      feedback_r <= REQ_I.wdata;
    end
  end

  // rescaling to engineering units and source gating
  assign fb_quot = {16'h0000, feedback_r} / SCALE_HUNDRED;
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      freq_whole_r <= '0;
      fb_whole_r <= '0;
      valid_r <= 1'b0;
    end else begin
      freq_whole_r <= freq_r / SCALE_HUNDRED;
      fb_whole_r <= fb_quot[15:0];
      valid_r <= (FREQ_SOURCE_SELECT_I == SRC_SEL_NETWORK);
    end
  end

  // trip counter, saturating at its top value
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      fault_count_r <= '0;
    end else if (TRIP_I && fault_count_r < FAULT_COUNT_MAX) begin
      fault_count_r <= fault_count_r + 16'h0001;
    end
  end

  // trip record capture; the older cause moves to the second record
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      fault1_r <= '0;
      fault1_state_r <= DS_INITIAL;
      fault2_cause_r <= '0;
    end else if (TRIP_I) begin
      fault1_r <= TRIP_SNAP_I;
      fault1_state_r <= DRIVE_STATE_I;
      fault2_cause_r <= fault1_r.cause;
    end
  end

  // sticky comm error flags; a new event beats a same-cycle reset
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      comm_err_r <= '0;
    end else begin
      comm_err_r <= (COMM_ERR_RESET_I ? '0 : comm_err_r) | COMM_ERR_EVENT_I;
    end
  end

  assign RSP_O = rsp_r;
  assign OUTPUT_FREQ_SETPOINT_O = freq_r;
  assign OUTPUT_FREQ_VALID_O = valid_r;
  assign FREQ_WHOLE_HZ_O = freq_whole_r;
  assign FEEDBACK_O = feedback_r;
  assign FEEDBACK_WHOLE_PCT_O = fb_whole_r;
  assign COMM_ERR_O = comm_err_r;

  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_read(logic [15:0] a);
    REQ_I.rd && !REQ_I.wr && REQ_I.addr == a;
  endsequence
  sequence s_hi_then_lo;
    REQ_I.wr && REQ_I.addr == ADDR_FREQ_HI ##1
      REQ_I.wr && REQ_I.addr == ADDR_FREQ_LO && !REQ_I.rd;
  endsequence

  property p_freq_range;
    freq_r <= FREQ_MAX;
  endproperty
  a_freq_range: assert property (p_freq_range) else $error("setpoint above range");

  property p_freq_pair;
    s_hi_then_lo |=> (freq_r[31:16] == $past(REQ_I.wdata, 2) || RSP_O.err);
  endproperty
  a_freq_pair: assert property (p_freq_pair) else $error("setpoint pair not committed");

  property p_src_gate;
    (FREQ_SOURCE_SELECT_I != SRC_SEL_NETWORK) |=> !OUTPUT_FREQ_VALID_O;
  endproperty
  a_src_gate: assert property (p_src_gate) else $error("setpoint valid with other source");

  property p_detail_read;
    s_read(ADDR_STATE_DETAIL) |=> RSP_O.ack && RSP_O.rdata == 16'($past(DRIVE_STATE_I));
  endproperty
  a_detail_read: assert property (p_detail_read) else $error("detail state misread");

  property p_coarse_trip;
    s_read(ADDR_STATE_COARSE) ##0 (DRIVE_STATE_I == DS_TRIPPING) |=>
      RSP_O.rdata == 16'(CS_TRIPPING);
  endproperty
  a_coarse_trip: assert property (p_coarse_trip) else $error("coarse state not tripping");

  property p_motion_read;
    s_read(ADDR_MOTION) |=> RSP_O.rdata == 16'($past(MOTION_PHASE_I));
  endproperty
  a_motion_read: assert property (p_motion_read) else $error("motion phase misread");

  property p_trip_capture;
    TRIP_I |=> fault1_state_r == $past(DRIVE_STATE_I) && fault1_r.cause == $past(TRIP_SNAP_I.cause)
      && fault1_r.current == $past(TRIP_SNAP_I.current)
      && fault1_r.voltage == $past(TRIP_SNAP_I.voltage);
  endproperty
  a_trip_capture: assert property (p_trip_capture) else $error("trip record not captured");

  property p_hours_read;
    s_read(ADDR_F1_RUN_HI) ##1 (s_read(ADDR_F1_PWR_LO) ##0 (!TRIP_I && !$past(TRIP_I))) |=>
      $past(RSP_O.rdata) == fault1_r.run_hours[31:16]
      && RSP_O.rdata == fault1_r.power_hours[15:0];
  endproperty
  a_hours_read: assert property (p_hours_read) else $error("trip hours misread");

  property p_scale;
    $stable(freq_r) |=> FREQ_WHOLE_HZ_O == $past(freq_r) / SCALE_HUNDRED;
  endproperty
  a_scale: assert property (p_scale) else $error("setpoint not rescaled");

  property p_addr0;
    s_read(ADDR_UNUSED) |=> RSP_O.ack && RSP_O.err;
  endproperty
  a_addr0: assert property (p_addr0) else $error("address zero accepted");

  property p_count_sat;
    (fault_count_r <= FAULT_COUNT_MAX) and (TRIP_I && fault_count_r < FAULT_COUNT_MAX
      |=> fault_count_r == $past(fault_count_r) + 16'h0001);
  endproperty
  a_count_sat: assert property (p_count_sat) else $error("trip counter wrong");

  property p_err_sticky;
    (|COMM_ERR_O) && !COMM_ERR_RESET_I |=> (COMM_ERR_O & $past(COMM_ERR_O)) == $past(COMM_ERR_O);
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped early");

  // every request gets its answer on the next edge
  property p_ack_once;
    (REQ_I.rd || REQ_I.wr) |=> RSP_O.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("request not answered");

  // a refused write leaves both writable values alone
  property p_refused;
    REQ_I.wr && wr_bad |=> $stable(freq_r) && $stable(feedback_r);
  endproperty
  a_refused: assert property (p_refused) else $error("refused write took effect");

  // an event in the reset cycle survives the reset
  property p_err_set;
    COMM_ERR_RESET_I |=> COMM_ERR_O == $past(COMM_ERR_EVENT_I);
  endproperty
  a_err_set: assert property (p_err_set) else $error("reset beat an event");

  // reserved window reads back zero with no error
  property p_rsv_read;
    REQ_I.rd && !REQ_I.wr && REQ_I.addr >= ADDR_RSV_FIRST && REQ_I.addr <= ADDR_RSV_LAST
      |=> RSP_O.ack && !RSP_O.err && RSP_O.rdata == RESERVED_VALUE;
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved read wrong");

  // an in-range feedback write is stored as sent
  property p_fb_write;
    REQ_I.wr && REQ_I.addr == ADDR_FEEDBACK && REQ_I.wdata <= FEEDBACK_MAX |=>
      feedback_r == $past(REQ_I.wdata);
  endproperty
  a_fb_write: assert property (p_fb_write) else $error("feedback not stored");
endmodule
`default_nettype wire

// ### verification/dstrb_bank_bench.sv
// self-checking bench for the drive status / trip register bank
// assumes the host model issues requests; bench drives drive-side inputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module dstrb_bank_bench;
  import dstrb_pkg::*;
  logic clk = 0, srst = 1, go = 0, trip = 0, done, err_rst = 0;
  logic [7:0] sel = 8'h03;
  logic [4:0] err_ev = '0, err_q;
  logic [31:0] sp, sp_hz;
  logic [15:0] fb, fb_pct, v;
  logic valid;
  logic [159:0] rnd;
  int n_fail = 0, comparisons = 0, cyc = 0, seed = 32'hd900;
  dstrb_req_t cmd = '0, req;
  dstrb_rsp_t rsp, seen;
  dstrb_detail_t dst = DS_INITIAL;
  dstrb_motion_t mph = MP_NONE;
  dstrb_trip_t snap = '0, s1;
  dstrb_bank i_dstrb_bank (.REF_CLK_I(clk), .SRST_I(srst), .REQ_I(req), .RSP_O(rsp),
    .FREQ_SOURCE_SELECT_I(sel), .DRIVE_STATE_I(dst), .MOTION_PHASE_I(mph), .TRIP_I(trip),
    .TRIP_SNAP_I(snap), .COMM_ERR_EVENT_I(err_ev), .COMM_ERR_RESET_I(err_rst),
    .OUTPUT_FREQ_SETPOINT_O(sp), .OUTPUT_FREQ_VALID_O(valid), .FREQ_WHOLE_HZ_O(sp_hz),
    .FEEDBACK_O(fb), .FEEDBACK_WHOLE_PCT_O(fb_pct), .COMM_ERR_O(err_q));
  dstrb_host i_dstrb_host (.clk_i(clk), .go_i(go), .cmd_i(cmd), .rsp_i(rsp), .req_o(req),
    .seen_o(seen), .done_o(done));
  // clock and cycle ceiling
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  // expected coarse code from the detail code
  function automatic logic [15:0] coarse(input logic [3:0] d);
    if (d == 4'h8) return 16'h0002;
    if (d == 4'h3 || d == 4'h5 || d == 4'h6 || d == 4'h7) return 16'h0001;
    return 16'h0000;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one register transfer through the host model
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    int i;
    @(posedge clk);
    go <= 1'b1;
    cmd <= '{rd: ~w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    `CHK("done", 1'b1, done)
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e, input logic er);
    xfer(1'b0, a, 16'h0000);
    `CHK("rdata", e, seen.rdata)
    `CHK("err", er, seen.err)
  endtask
  task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic er);
    xfer(1'b1, a, d);
    `CHK("werr", er, seen.err)
  endtask
  // two requests on consecutive cycles; returns once the first answer is held
  task automatic burst(input dstrb_req_t c1, input dstrb_req_t c2);
    @(posedge clk);
    go <= 1'b1;
    cmd <= c1;
    @(posedge clk);
    cmd <= c2;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("sp_rst", 32'h0, sp)
    `CHK("err_rst", 5'h00, err_q)
    rd_chk(ADDR_FAULT_COUNT, 16'h0000, 1'b0);
    tend("reset");
    // setpoint: walk value, upper bound, one past, random in range
    wr_chk(ADDR_FREQ_HI, 16'h0000, 1'b0);
    wr_chk(ADDR_FREQ_LO, 16'h7530, 1'b0);
    `CHK("sp", 32'd30000, sp)
    @(posedge clk);
    #1;
    `CHK("hz", 32'd300, sp_hz)
    `CHK("valid", 1'b1, valid)
    wr_chk(ADDR_FREQ_LO, 16'h9C40, 1'b0);
    wr_chk(ADDR_FREQ_LO, 16'h9C41, 1'b1);
    `CHK("sp_keep", 32'd40000, sp)
    wr_chk(ADDR_FREQ_HI, 16'h0001, 1'b0);
    wr_chk(ADDR_FREQ_LO, 16'h0000, 1'b1);
    // back-to-back pair: high staged, low commits the next cycle
    burst('{rd: 1'b0, wr: 1'b1, addr: ADDR_FREQ_HI, wdata: 16'h0000},
      '{rd: 1'b0, wr: 1'b1, addr: ADDR_FREQ_LO, wdata: 16'h1388});
    `CHK("pair_hi_err", 1'b0, seen.err)
    `CHK("sp_pair", 32'd5000, sp)
    @(posedge clk);
    #1;
    `CHK("pair_lo_err", 1'b0, seen.err)
    v = 16'($unsigned($random(seed)) % 40001);
    wr_chk(ADDR_FREQ_LO, v, 1'b0);
    rd_chk(ADDR_FREQ_HI, 16'h0000, 1'b0);
    rd_chk(ADDR_FREQ_LO, v, 1'b0);
    `CHK("hz_rnd", {16'h0, v} / 100, sp_hz)
    sel <= 8'h02;
    repeat (3) @(posedge clk);
    #1;
    `CHK("valid_off", 1'b0, valid)
    tend("setpoint");
    // feedback value and its bound
    v = 16'($unsigned($random(seed)) % 10001);
    wr_chk(ADDR_FEEDBACK, v, 1'b0);
    wr_chk(ADDR_FEEDBACK, 16'h2711, 1'b1);
    rd_chk(ADDR_FEEDBACK, v, 1'b0);
    `CHK("fb", v, fb)
    `CHK("fb_pct", v / 100, fb_pct)
    tend("feedback");
    // status words for every detail code and motion codes 1 to 10
    for (int c = 0; c < 10; c++) begin
      if (c != 1) begin
        dst <= dstrb_detail_t'(c);
        rd_chk(ADDR_STATE_DETAIL, c[15:0], 1'b0);
        rd_chk(ADDR_STATE_COARSE, coarse(c[3:0]), 1'b0);
      end
    end
    for (int c = 1; c < 11; c++) begin
      mph <= dstrb_motion_t'(c);
      rd_chk(ADDR_MOTION, c[15:0], 1'b0);
    end
    tend("status");
    // reserved, unmapped and read-only places
    for (int a = 7; a <= 16; a++) rd_chk(a[15:0], 16'h0000, 1'b0);
    wr_chk(ADDR_RSV_FIRST, 16'h1234, 1'b1);
    wr_chk(ADDR_MOTION, 16'h0001, 1'b1);
    wr_chk(ADDR_F1_CAUSE, 16'h0001, 1'b1);
    rd_chk(ADDR_UNUSED, 16'h0000, 1'b1);
    rd_chk(16'h001D, 16'h0000, 1'b1);
    tend("access");
    // two trips with random snapshots
    for (int t = 0; t < 2; t++) begin
      s1 = snap;
      @(posedge clk);
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      snap <= rnd[143:0];
      dst <= dstrb_detail_t'(8);
      trip <= 1'b1;
      @(posedge clk);
      trip <= 1'b0;
    end
    rd_chk(ADDR_FAULT_COUNT, 16'h0002, 1'b0);
    rd_chk(ADDR_F1_CAUSE, snap.cause, 1'b0);
    rd_chk(ADDR_F1_STATE, 16'h0008, 1'b0);
    rd_chk(ADDR_F1_FREQ_HI, snap.freq[31:16], 1'b0);
    rd_chk(ADDR_F1_FREQ_LO, snap.freq[15:0], 1'b0);
    rd_chk(ADDR_F1_CURRENT, snap.current, 1'b0);
    rd_chk(ADDR_F1_VOLTAGE, snap.voltage, 1'b0);
    rd_chk(ADDR_F1_RUN_HI, snap.run_hours[31:16], 1'b0);
    rd_chk(ADDR_F1_RUN_LO, snap.run_hours[15:0], 1'b0);
    rd_chk(ADDR_F1_PWR_HI, snap.power_hours[31:16], 1'b0);
    rd_chk(ADDR_F1_PWR_LO, snap.power_hours[15:0], 1'b0);
    rd_chk(ADDR_F2_CAUSE, s1.cause, 1'b0);
    // hours pair read back to back
    burst('{rd: 1'b1, wr: 1'b0, addr: ADDR_F1_RUN_HI, wdata: 16'h0000},
      '{rd: 1'b1, wr: 1'b0, addr: ADDR_F1_PWR_LO, wdata: 16'h0000});
    `CHK("run_hi_b2b", snap.run_hours[31:16], seen.rdata)
    @(posedge clk);
    #1;
    `CHK("pwr_lo_b2b", snap.power_hours[15:0], seen.rdata)
    tend("trip");
    // sticky errors, cleared while running, set wins over reset
    dst <= DS_RUNNING;
    @(posedge clk);
    err_ev <= 5'h1E;
    @(posedge clk);
    err_ev <= 5'h00;
    repeat (4) @(posedge clk);
    #1;
    `CHK("err_hold", 5'h1E, err_q)
    @(posedge clk);
    err_rst <= 1'b1;
    err_ev <= 5'h03;
    @(posedge clk);
    err_rst <= 1'b0;
    err_ev <= 5'h00;
    @(posedge clk);
    #1;
    `CHK("err_clr", 5'h03, err_q)
    tend("errors");
    // mid-run reset clears the bank again
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("sp_rst2", 32'h0, sp)
    `CHK("fb_rst2", 16'h0, fb)
    `CHK("err_rst2", 5'h00, err_q)
    rd_chk(ADDR_FAULT_COUNT, 16'h0000, 1'b0);
    rd_chk(ADDR_F1_CAUSE, 16'h0000, 1'b0);
    tend("reset again");
    stop_test();
  end
endmodule
`default_nettype wire

// ### verification/dstrb_host.sv
// host-side model of the network master: one register request for each cycle that go is high
// assumes the bench drives go and cmd just after the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module dstrb_host (
  input wire logic clk_i,
  input wire logic go_i,
  input wire dstrb_pkg::dstrb_req_t cmd_i,
  input wire dstrb_pkg::dstrb_rsp_t rsp_i,
  output var dstrb_pkg::dstrb_req_t req_o,
  output var dstrb_pkg::dstrb_rsp_t seen_o,
  output logic done_o
);
  import dstrb_pkg::*;
  // request stands one cycle; values come pre-scaled into listed ranges
  always_ff @(posedge clk_i) begin
    req_o <= go_i ? cmd_i : '0;
  end
  // keep the answer taken on the edge where ack is high
  always_ff @(posedge clk_i) begin
    if (rsp_i.ack) begin
      seen_o <= rsp_i;
      done_o <= 1'b1;
    end else if (go_i) begin
      done_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire
